/* bench/i2cmb_host.sv */
`timescale 1ns/10ps
module i2cmb_host (
    // Clock
    input wire logic mclk_i,
    // Device pull-down enables
    input wire logic scl_oe_i,
    input wire logic sda_oe_i,
    // Resolved bus levels
    output logic scl_o,
    output logic sda_o
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    // Pull-ups: a released line reads high
    assign scl_o = ~(scl_low | scl_oe_i);
    assign sda_o = ~(sda_low | sda_oe_i);
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic bitx(input logic b, output logic s);
        int k;
        scl_low = 1'b1;
        tick(2);
        sda_low = ~b;
        tick(4);
        scl_low = 1'b0;
        k = 0;
        tick(1);
        while (scl_o !== 1'b1 && k < 500) begin
            tick(1);
            k++;
        end
        tick(4);
        s = sda_o;
        tick(2);
    endtask
    // Extra SCL pulse first, so a repeated start works too
    task automatic start();
        logic s;
        bitx(1'b1, s);
        sda_low = 1'b1;
        tick(6);
    endtask
    task automatic stop();
        logic s;
        bitx(1'b0, s);
        sda_low = 1'b0;
        tick(6);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
        bitx(last, s);
    endtask
endmodule

/* bench/i2cmb_port_bench.sv */
`timescale 1ns/10ps
module i2cmb_port_bench import i2cmb_pkg::*;;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic addr_sel_i = 1'b0;
    logic wake_request_n_i = 1'b0;
    logic rd_valid_i = 1'b0;
    logic [7:0] rd_data_i = 8'h00;
    logic scl, sda, scl_oe, sda_oe, wr_valid, rd_req;
    logic [7:0] rd_loc;
    logic [15:0] sh = 16'h0000;
    logic busy;
    int n_stretch = 0;
    i2cmb_wr_t wr;
    i2cmb_wr_t wq[$];
    int miscompares = 0;
    int n_checks = 0;
    always #25 mclk_i = ~mclk_i;
    i2cmb_port i2cmb_port_i(.mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl),
        .sda_i(sda), .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe),
        .addr_sel_i(addr_sel_i), .wake_request_n_i(wake_request_n_i),
        .wr_o(wr), .wr_valid_o(wr_valid), .rd_loc_o(rd_loc), .rd_req_o(rd_req),
        .rd_data_i(rd_data_i), .rd_valid_i(rd_valid_i), .busy_o(busy));
    i2cmb_host i2cmb_host_i(.mclk_i(mclk_i), .scl_oe_i(scl_oe),
        .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    ////////////////////////////////////////////////////////////////////
    // Mailbox answers 15 cycles late, past the SCL high time, so the
    // device has to stretch the clock before the first data bit
    always @(posedge mclk_i) begin
        #1;
        sh = {sh[14:0], rd_req};
        rd_valid_i = sh[15];
        if (scl_oe === 1'b1) n_stretch++;
        rd_data_i = ~rd_loc;
        if (wr_valid === 1'b1) wq.push_back(wr);
    end
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr_txn(input logic [6:0] a, input logic [7:0] q[$],
        input logic ex, input logic sr);
        logic ack;
        i2cmb_host_i.start();
        i2cmb_host_i.wbyte({a, 1'b0}, ack);
        chk(17'(ack), 17'(ex));
        foreach (q[i]) if (ack) i2cmb_host_i.wbyte(q[i], ack);
        if (!sr) i2cmb_host_i.stop();
    endtask
    task automatic rd_txn(input int n);
        logic ack;
        logic [7:0] b;
        i2cmb_host_i.start();
        i2cmb_host_i.wbyte({7'h5A, 1'b1}, ack);
        chk(17'(ack), 17'h1);
        chk(17'(busy), 17'h1);
        for (int i = 0; i < n; i++) begin
            i2cmb_host_i.rbyte(i == n - 1, b);
            chk({9'h0, b}, 17'h000DF);
        end
        i2cmb_host_i.stop();
        chk(17'(busy), 17'h0);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic sc_write();
        logic [7:0] d[3] = '{8'hA1, 8'hB2, 8'hC3};
        wr_txn(7'h5A, '{8'h11}, 1'b1, 1'b0);
        chk(17'(wq.size()), 17'h0);
        wr_txn(7'h5A, '{8'h05, 8'hA1, 8'hB2, 8'hC3}, 1'b1, 1'b0);
        chk(17'(wq.size()), 17'h3);
        for (int i = 0; i < 3; i++) chk(wq[i], {8'h05, d[i], i == 0});
        wq.delete();
    endtask
    task automatic sc_read();
        wr_txn(7'h5A, '{8'h20}, 1'b1, 1'b1);
        rd_txn(1);
        rd_txn(2);
        rd_txn(3);
        chk(17'(n_stretch != 0), 17'h1);
        chk(17'(wq.size()), 17'h0);
    endtask
    task automatic sc_refuse();
        wr_txn(7'h5B, '{8'h33}, 1'b0, 1'b0);
        addr_sel_i = 1'b1;
        wr_txn(7'h5B, '{8'h33, 8'h44}, 1'b1, 1'b0);
        addr_sel_i = 1'b0;
        wake_request_n_i = 1'b1;
        wr_txn(7'h5A, '{8'h33, 8'h55}, 1'b0, 1'b0);
        wake_request_n_i = 1'b0;
        chk(17'(wq.size()), 17'h1);
        chk(wq[0], {8'h33, 8'h44, 1'b1});
    endtask
    initial begin
        repeat (3) @(posedge mclk_i);
        #1;
        rst_b_i = 1'b1;
        repeat (4) @(posedge mclk_i);
        sc_write();
        sc_read();
        sc_refuse();
        close_out();
    end
    // Whole run is well under 1 ms; 3 ms means a hang
    initial begin
        #3_000_000;
        miscompares++;
        close_out();
    end
endmodule

/* bench/i2cmb_props.sv */
`timescale 1ns/10ps
module i2cmb_props
    import i2cmb_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Watched ports
    input wire logic scl_o,
    input wire logic sda_o,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic wake_request_n_i,
    input wire i2cmb_wr_t wr_o,
    input wire logic wr_valid_o,
    input wire logic rd_req_o,
    input wire logic busy_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    open_drain_a: assert property (!scl_o && !sda_o)
        else $error("pin driven high");
    wr_pulse_a: assert property (wr_valid_o |=> !wr_valid_o)
        else $error("write pulse too long");
    rd_pulse_a: assert property (rd_req_o |=> !rd_req_o)
        else $error("fetch pulse too long");
    same_loc_a: assert property (wr_valid_o && !wr_o.first |->
        wr_o.loc == $past(wr_o.loc)) else $error("location moved");
    stretch_a: assert property (scl_oe_o |-> busy_o)
        else $error("stretch while idle");
    wake_gate_a: assert property (wake_request_n_i && !busy_o |=>
        !busy_o) else $error("busy while asleep");
    idle_quiet_a: assert property (!busy_o [*2] |->
        !sda_oe_o && !scl_oe_o) else $error("bus driven while idle");
    fetch_busy_a: assert property (rd_req_o |->
        busy_o && !wr_valid_o) else $error("stray fetch");
endmodule
////////////////////////////////////////////////////////////////////////
bind i2cmb_port i2cmb_props i2cmb_props_i(.mclk_i(mclk_i),
    .rst_b_i(rst_b_i), .scl_o(scl_o), .sda_o(sda_o), .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o), .wake_request_n_i(wake_request_n_i), .wr_o(wr_o),
    .wr_valid_o(wr_valid_o), .rd_req_o(rd_req_o), .busy_o(busy_o));

/* include/i2cmb_pkg.sv */
package i2cmb_pkg;

    // Upper six bits of the 7-bit target address; LSB comes from the strap
    localparam logic [5:0] I2CMB_ADDR_HI = 6'h2D;
    localparam int I2CMB_BYTE_BITS = 8;
    localparam logic [7:0] I2CMB_LOC_RESET = 8'h00;
    localparam logic [2:0] I2CMB_BIT_RESET = 3'h7;
    localparam logic [7:0] I2CMB_BYTE_RESET = 8'h00;

    typedef enum logic [2:0] {
        I2CMB_IDLE = 3'b000,
        I2CMB_ADDR = 3'b001,
        I2CMB_AACK = 3'b011,
        I2CMB_RXB  = 3'b010,
        I2CMB_WACK = 3'b110,
        I2CMB_TXB  = 3'b111,
        I2CMB_RACK = 3'b101,
        I2CMB_SKIP = 3'b100
    } i2cmb_state_t;

    // One byte written by the host into the selected mailbox
    typedef struct packed {
        logic [7:0] loc;
        logic [7:0] data;
        logic first;
    } i2cmb_wr_t;

endpackage

/* verilog/i2cmb_port.sv */
`timescale 1ns/10ps
// Functional notes
// - First byte after address in a write selects location; rest is data.
// - Location stays fixed for every data byte; pointer never increments.
// - Location-only write updates pointer and changes no register.
// - Single data byte is stored into the selected register.
// - Several data bytes are all delivered in order to the same location.
// - Location kept across repeated start; read returns its data.
// - Separate reads keep using the location until a new select.
// - Answer 7-bit address whose LSB follows the strap pin.
module i2cmb_port
    import i2cmb_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Bus pins, open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    // Strap and wake
    input wire logic addr_sel_i,
    input wire logic wake_request_n_i,
    // Mailbox side
    output i2cmb_wr_t wr_o,
    output logic wr_valid_o,
    output logic [7:0] rd_loc_o,
    output logic rd_req_o,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i,
    output logic busy_o
);

    ////////////////////////////////////////////////////////////////////////
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    i2cmb_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic rw_read;
    logic loc_phase;
    logic first_data;
    logic [7:0] loc;
    logic [7:0] tx_byte;
    logic waiting;
    logic strap;

    assign scl_rise = scl_i && !scl_q;
    assign scl_fall = !scl_i && scl_q;
    assign start_det = scl_i && scl_q && sda_q && !sda_i;
    assign stop_det = scl_i && scl_q && !sda_q && sda_i;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Strap re-sampled by clocked logic on every cycle the engine is idle
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            strap <= 1'b0;
        end else if (state == I2CMB_IDLE) begin
            strap <= addr_sel_i;
        end
    end

    function automatic logic addr_match(input logic [7:0] b, input logic s);
        addr_match = (b[7:1] == {I2CMB_ADDR_HI, s});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Byte engine; sleeping device ignores the bus
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state <= I2CMB_IDLE;
            bit_cnt <= I2CMB_BIT_RESET;
            shift <= I2CMB_BYTE_RESET;
            rw_read <= 1'b0;
            loc_phase <= 1'b0;
            first_data <= 1'b0;
        end else if (start_det) begin
            state <= wake_request_n_i ? I2CMB_IDLE : I2CMB_ADDR;
            bit_cnt <= I2CMB_BIT_RESET;
            // Stale byte must not pose as an address on the first fall
            shift <= I2CMB_BYTE_RESET;
        end else if (stop_det) begin
            state <= I2CMB_IDLE;
        end else begin
            case (state)
                I2CMB_ADDR, I2CMB_RXB: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_i};
                        bit_cnt <= bit_cnt - 3'h1;
                    end else if (scl_fall && bit_cnt == I2CMB_BIT_RESET
                                 && state == I2CMB_ADDR
                                 && shift != I2CMB_BYTE_RESET) begin
                        if (addr_match(shift, strap)) begin
                            state <= I2CMB_AACK;
                            rw_read <= shift[0];
                            loc_phase <= !shift[0];
                            first_data <= 1'b1;
                        end else begin
                            state <= I2CMB_SKIP;
                        end
                    end else if (scl_fall && bit_cnt == I2CMB_BIT_RESET
                                 && state == I2CMB_RXB) begin
                        state <= I2CMB_WACK;
                    end
                end
                I2CMB_AACK, I2CMB_WACK: begin
                    if (scl_fall) begin
                        if (state == I2CMB_WACK && !loc_phase) begin
                            first_data <= 1'b0;
                        end
                        if (state == I2CMB_WACK) begin
                            loc_phase <= 1'b0;
                        end
                        shift <= I2CMB_BYTE_RESET;
                        state <= rw_read ? I2CMB_TXB : I2CMB_RXB;
                    end
                end
                I2CMB_TXB: begin
                    if (scl_fall && !waiting) begin
                        if (bit_cnt == 3'h0) begin
                            state <= I2CMB_RACK;
                        end
                        bit_cnt <= bit_cnt - 3'h1;
                    end
                end
                I2CMB_RACK: begin
                    if (scl_rise) begin
                        state <= sda_i ? I2CMB_SKIP : I2CMB_RACK;
                    end else if (scl_fall) begin
                        state <= I2CMB_TXB;
                    end
                end
                I2CMB_SKIP: begin
                    state <= I2CMB_SKIP;
                end
                default: begin
                    state <= I2CMB_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Location pointer: only the first written byte moves it
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            loc <= I2CMB_LOC_RESET;
        end else if (state == I2CMB_WACK && scl_fall && loc_phase) begin
            loc <= shift;
        end
    end

    // Data bytes go out with the held location
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            wr_o <= '0;
            wr_valid_o <= 1'b0;
        end else begin
            wr_valid_o <= state == I2CMB_WACK && scl_fall && !loc_phase;
            if (state == I2CMB_WACK && scl_fall && !loc_phase) begin
                wr_o.loc <= loc;
                wr_o.data <= shift;
                wr_o.first <= first_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read fetch; SCL held low until the mailbox answers
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            waiting <= 1'b0;
            rd_req_o <= 1'b0;
            rd_loc_o <= I2CMB_LOC_RESET;
            tx_byte <= I2CMB_BYTE_RESET;
        end else begin
            rd_req_o <= 1'b0;
            if ((state == I2CMB_AACK && rw_read
                 || state == I2CMB_RACK && !sda_i) && scl_rise) begin
                waiting <= 1'b1;
                rd_req_o <= 1'b1;
                rd_loc_o <= loc;
            end else if (waiting && rd_valid_i) begin
                waiting <= 1'b0;
                tx_byte <= rd_data_i;
            end else if (state == I2CMB_TXB && scl_fall && !waiting) begin
                tx_byte <= {tx_byte[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            sda_oe_o <= state == I2CMB_AACK || state == I2CMB_WACK
                        || (state == I2CMB_TXB && !waiting && !tx_byte[7]);
            scl_oe_o <= waiting && !scl_i;
            busy_o <= state != I2CMB_IDLE && state != I2CMB_SKIP;
        end
    end

endmodule
